/* bench/boxcar_average_decimator_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module boxcar_average_decimator_bench;
  typedef struct {int fin; int f; int grp; int extra; int base; int step; int lvl; int st;} bxavg_row_t;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, start = 1'b0, stop = 1'b0, run = 1'b0;
  logic [8:0]  factor = 9'h002;
  logic [15:0] lvl = 16'h0000, n = 16'h0000, base = 16'h0000, step = 16'h0000;
  logic [1:0]  stall = 2'h0;
  logic [15:0] sample, sent, tgr, cgr, count;
  logic [7:0]  tph, cph;
  logic        s_valid, s_ready, a_valid, a_ready, trig, active;
  logic        trig_en = 1'b1;
  logic [23:0] a_data;
  int          err_total = 0, checks_done = 0, trig_n = 0;
  bxavg_row_t  rows[7] = '{'{2, 2, 3, 1, 100, 1, 0, 0}, '{256, 256, 1, 0, -300, 3, 0, 1},
    '{3, 3, 4, 2, -7, 5, 0, 0}, '{1, 2, 2, 0, -5, 2, 0, 0}, '{300, 256, 1, 5, 10, -1, 0, 1},
    '{4, 4, 2, 0, 32767, 0, 0, 0}, '{2, 2, 12, 1, 0, 1, 5, 2}};

  always #5 clock_i = ~clock_i;

  bxavg_top bxavg_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .acq_start_i(start), .acq_stop_i(stop),
    .factor_i(factor), .sample_i(sample), .sample_valid_i(s_valid), .sample_ready_o(s_ready),
    .trig_en_i(trig_en), .trig_level_i(lvl), .avg_data_o(a_data), .avg_valid_o(a_valid),
    .avg_ready_i(a_ready), .trig_o(trig), .trig_phase_o(tph), .trig_group_o(tgr),
    .avg_count_o(count), .acq_active_o(active));

  bxavg_adc_mem bxavg_adc_mem_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .run_i(run), .n_i(n),
    .base_i(base), .step_i(step), .stall_i(stall), .active_i(active), .start_i(start),
    .sample_ready_i(s_ready), .avg_valid_i(a_valid), .avg_data_i(a_data), .sample_o(sample),
    .sample_valid_o(s_valid), .avg_ready_o(a_ready), .sent_o(sent));

  always @(negedge clock_i) begin
    if (trig === 1'b1) begin
      trig_n++;
      cph = tph;
      cgr = tgr;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic int sv(bxavg_row_t r, int k);
    logic [15:0] w;
    w = 16'(r.base + r.step * k);
    return int'($signed(w));
  endfunction

  // floor of sum*256/f, as a 24-bit word
  function automatic logic [23:0] exp_avg(bxavg_row_t r, int g);
    longint s, q;
    s = 0;
    for (int k = 0; k < r.f; k++)
      s += sv(r, g * r.f + k);
    q = (s * 256) / r.f;
    if (s < 0 && (s * 256) % r.f != 0)
      q -= 1;
    return q[23:0];
  endfunction

  task automatic run_acq(bxavg_row_t r);
    int i, tk, tot;
    tot = r.f * r.grp + r.extra;
    tk = -1;
    for (int k = tot - 1; k >= 1; k--)
      if (sv(r, k - 1) < r.lvl && sv(r, k) >= r.lvl)
        tk = k;
    @(negedge clock_i);
    factor = r.fin[8:0];
    lvl = r.lvl[15:0];
    stall = r.st[1:0];
    start = 1'b1;
    bxavg_adc_mem_i.got.delete();
    trig_n = 0;
    @(negedge clock_i);
    start = 1'b0;
    n = tot[15:0];
    base = r.base[15:0];
    step = r.step[15:0];
    run = 1'b1;
    for (i = 0; i < 4000; i++) begin
      @(negedge clock_i);
      if (r.st == 2 && i == 599) begin
        // full buffer with memory stalled holds the stream back
        check(sent < n, 1);
        stall = 2'h0;
      end
      if (sent == n && bxavg_adc_mem_i.got.size() == r.grp)
        break;
    end
    if (i == 4000) begin
      err_total++;
      conclude();
    end
    repeat (3) @(negedge clock_i);
    check(bxavg_adc_mem_i.got.size(), r.grp);
    check(count, r.grp);
    check(a_valid, 0);
    for (int g = 0; g < r.grp; g++)
      check(bxavg_adc_mem_i.got[g], exp_avg(r, g));
    check(trig_n, (tk < 0 || !trig_en) ? 0 : 1);
    if (tk >= 0 && trig_en) begin
      check(cph, tk % r.f);
      check(cgr, tk / r.f);
    end
    stop = 1'b1;
    run = 1'b0;
    @(negedge clock_i);
    stop = 1'b0;
    @(negedge clock_i);
    check(active, 0);
  endtask

  initial begin
    repeat (2) @(negedge clock_i);
    check({a_valid, active, trig, count}, 0);
    rst_n_i = 1'b1;
    // rows 0, 2, 4 and 6 also leave a partial group that the next start must drop
    foreach (rows[j])
      run_acq(rows[j]);
    @(negedge clock_i);
    factor = 9'h004;
    start = 1'b1;
    @(negedge clock_i);
    start = 1'b0;
    n = 16'h0040;
    run = 1'b1;
    repeat (10) @(negedge clock_i);
    rst_n_i = 1'b0;
    run = 1'b0;
    repeat (2) @(negedge clock_i);
    // mid-run reset leaves nothing behind
    check({a_valid, active, s_ready, count}, 0);
    rst_n_i = 1'b1;
    run_acq(rows[2]);
    // detection switched off must stay quiet across a crossing
    trig_en = 1'b0;
    run_acq(rows[3]);
    conclude();
  end
endmodule // boxcar_average_decimator_bench

`default_nettype wire

/* bench/bxavg_adc_mem.sv */
`timescale 1ns/1ns
`default_nettype none

// converter stream on one side, acquisition memory on the other
module bxavg_adc_mem (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic [15:0] n_i,
  input  wire logic [15:0] base_i,
  input  wire logic [15:0] step_i,
  input  wire logic [1:0]  stall_i,
  input  wire logic        active_i,
  input  wire logic        start_i,
  input  wire logic        sample_ready_i,
  input  wire logic        avg_valid_i,
  input  wire logic [23:0] avg_data_i,
  output logic [15:0]      sample_o,
  output logic             sample_valid_o,
  output logic             avg_ready_o,
  output logic [15:0]      sent_o
);
  logic [23:0] got[$];
  logic        slow;

  initial begin
    sample_o = 16'h0000;
    sample_valid_o = 1'b0;
    avg_ready_o = 1'b0;
    sent_o = 16'h0000;
    slow = 1'b0;
  end

  always @(posedge clock_i) begin
    if (!rst_n_i || !run_i)
      sent_o <= 16'h0000;
    else if (sample_valid_o && sample_ready_i && active_i && !start_i)
      sent_o <= sent_o + 16'h0001;
    if (rst_n_i && avg_valid_i && avg_ready_o)
      got.push_back(avg_data_i);
  end

  // idle data line toggles so a stale word never looks valid
  always @(negedge clock_i) begin
    slow <= !slow;
    avg_ready_o <= (stall_i == 2'h0) || (stall_i == 2'h1 && slow);
    if (run_i && sent_o < n_i) begin
      sample_valid_o <= 1'b1;
      sample_o <= base_i + step_i * sent_o;
    end else begin
      sample_valid_o <= 1'b0;
      sample_o <= ~sample_o;
    end
  end
endmodule // bxavg_adc_mem

`default_nettype wire

/* src/bxavg_cfg.svh */
`ifndef BXAVG_CFG_SVH
`define BXAVG_CFG_SVH

// sample and result widths
`define BXA_IN_W        16
`define BXA_OUT_W       24
`define BXA_FRAC_W      8
`define BXA_FACT_W      9
`define BXA_REM_W       10
`define BXA_DVD_W       32

// averaging factor limits
`define BXA_FACT_MIN    9'h002
`define BXA_FACT_MAX    9'h100

// divider steps, one quotient bit each
`define BXA_DIV_STEPS   6'h20
`define BXA_DIV_LAST    6'h1f

// result buffer depth, power of two
`define BXA_FIFO_DEPTH  8

// group counter width
`define BXA_GRP_W       16

`endif

/* src/bxavg_fifo.sv */
`timescale 1ns/1ns
`default_nettype none

// depth must be a power of two: the pointers wrap on their own width
module bxavg_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty       = (wr_ptr == rd_ptr);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push        = in_valid_i && !full;
  assign pop         = out_ready_i && !empty;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
    end
  end

  fifo_bounds_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    full |=> !(wr_ptr == rd_ptr))
    else $error("fifo wrapped from full to empty");

endmodule // bxavg_fifo

`default_nettype wire

/* src/bxavg_pkg.sv */
package bxavg_pkg;

  typedef enum logic [1:0] {
    BXAVG_IDLE = 2'b00,
    BXAVG_DIV  = 2'b01,
    BXAVG_PUSH = 2'b10
  } bxavg_div_st_t;

  typedef logic [15:0] bxavg_sample_t;

endpackage : bxavg_pkg

/* src/bxavg_top.sv */
`timescale 1ns/1ns
`default_nettype none

`include "bxavg_cfg.svh"

module bxavg_top #(
  parameter int FIFO_DEPTH = `BXA_FIFO_DEPTH
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  acq_start_i,
  input  wire logic                  acq_stop_i,
  input  wire logic [`BXA_FACT_W-1:0] factor_i,
  input  wire logic [`BXA_IN_W-1:0]  sample_i,
  input  wire logic                  sample_valid_i,
  output logic                       sample_ready_o,
  input  wire logic                  trig_en_i,
  input  wire logic [`BXA_IN_W-1:0]  trig_level_i,
  output logic [`BXA_OUT_W-1:0]      avg_data_o,
  output logic                       avg_valid_o,
  input  wire logic                  avg_ready_i,
  output logic                       trig_o,
  output logic [7:0]                 trig_phase_o,
  output logic [`BXA_GRP_W-1:0]      trig_group_o,
  output logic [`BXA_GRP_W-1:0]      avg_count_o,
  output logic                       acq_active_o
);

  bxavg_pkg::bxavg_div_st_t st;
  bxavg_pkg::bxavg_div_st_t next_st;

  logic [`BXA_FACT_W-1:0] fac;
  logic [`BXA_FACT_W-1:0] next_fac;
  logic [`BXA_FACT_W-1:0] cnt;
  logic [`BXA_FACT_W-1:0] next_cnt;
  logic [`BXA_OUT_W-1:0]  acc;
  logic [`BXA_OUT_W-1:0]  sum_final;
  logic [`BXA_OUT_W-1:0]  dvd_hold;
  logic [`BXA_DVD_W-1:0]  dq;
  logic [`BXA_REM_W-1:0]  rem;
  logic [`BXA_REM_W-1:0]  trial;
  logic [5:0]             step;
  logic [`BXA_IN_W-1:0]   uval;
  logic [`BXA_IN_W-1:0]   prev_s;
  logic                   prev_ok;
  logic                   armed;
  logic                   accept;
  logic                   complete;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [`BXA_OUT_W-1:0]  fifo_out_data;
  logic                   fifo_pop;
  logic [`BXA_OUT_W-1:0]  result;

  // out-of-range requests snap to the nearest legal factor
  function automatic logic [`BXA_FACT_W-1:0] clamp_factor(input logic [`BXA_FACT_W-1:0] f);
    if (f < `BXA_FACT_MIN) begin
      clamp_factor = `BXA_FACT_MIN;
    end else if (f > `BXA_FACT_MAX) begin
      clamp_factor = `BXA_FACT_MAX;
    end else begin
      clamp_factor = f;
    end
  endfunction

  function automatic logic rising_cross(input logic [`BXA_IN_W-1:0] p,
                                        input logic [`BXA_IN_W-1:0] c,
                                        input logic [`BXA_IN_W-1:0] lvl);
    rising_cross = ($signed(p) < $signed(lvl)) && ($signed(c) >= $signed(lvl));
  endfunction

  // offset binary keeps the sum and the division unsigned
  assign uval      = {~sample_i[`BXA_IN_W-1], sample_i[`BXA_IN_W-2:0]};
  assign accept    = sample_valid_i && sample_ready_o && acq_active_o && !acq_start_i;
  assign complete  = accept && (cnt == (fac - 9'h001));
  assign sum_final = acc + {8'h00, uval};
  assign trial     = {rem[`BXA_REM_W-2:0], dq[`BXA_DVD_W-1]};
  assign result    = {~dq[`BXA_OUT_W-1], dq[`BXA_OUT_W-2:0]};
  assign fifo_pop  = fifo_out_valid && (!avg_valid_o || avg_ready_i);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      acq_active_o <= 1'b0;
    end else if (acq_start_i) begin
      acq_active_o <= 1'b1;
    end else if (acq_stop_i) begin
      acq_active_o <= 1'b0;
    end
  end

  always_comb begin
    next_fac = acq_start_i ? clamp_factor(factor_i) : fac;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fac <= `BXA_FACT_MIN;
    end else begin
      fac <= next_fac;
    end
  end

  always_comb begin
    if (acq_start_i || complete) begin
      next_cnt = 9'h000;
    end else if (accept) begin
      next_cnt = cnt + 9'h001;
    end else begin
      next_cnt = cnt;
    end
  end

  always_comb begin
    next_st = st;
    if (acq_start_i) begin
      next_st = bxavg_pkg::BXAVG_IDLE;
    end else begin
      case (st)
        bxavg_pkg::BXAVG_IDLE: begin
          next_st = complete ? bxavg_pkg::BXAVG_DIV : bxavg_pkg::BXAVG_IDLE;
        end
        bxavg_pkg::BXAVG_DIV: begin
          next_st = (step == `BXA_DIV_LAST) ? bxavg_pkg::BXAVG_PUSH : bxavg_pkg::BXAVG_DIV;
        end
        bxavg_pkg::BXAVG_PUSH: begin
          next_st = fifo_in_ready ? bxavg_pkg::BXAVG_IDLE : bxavg_pkg::BXAVG_PUSH;
        end
        default: begin
          next_st = bxavg_pkg::BXAVG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st <= bxavg_pkg::BXAVG_IDLE;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt <= 9'h000;
      acc <= 24'h000000;
    end else begin
      cnt <= next_cnt;
      if (acq_start_i || complete) begin
        acc <= 24'h000000;
      end else if (accept) begin
        acc <= sum_final;
      end
    end
  end

  // only the last sample of a group waits for the divider; the rest keep flowing
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sample_ready_o <= 1'b0;
    end else begin
      sample_ready_o <= !((next_st != bxavg_pkg::BXAVG_IDLE) && (next_cnt == (next_fac - 9'h001)));
    end
  end

  // restoring divide of sum by factor
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dq       <= 32'h00000000;
      rem      <= 10'h000;
      step     <= 6'h00;
      dvd_hold <= 24'h000000;
    end else if (complete) begin
      dq       <= {sum_final, 8'h00};
      rem      <= 10'h000;
      step     <= 6'h00;
      dvd_hold <= sum_final;
    end else if (st == bxavg_pkg::BXAVG_DIV) begin
      step <= step + 6'h01;
      if (trial >= {1'b0, fac}) begin
        rem <= trial - {1'b0, fac};
        dq  <= {dq[`BXA_DVD_W-2:0], 1'b1};
      end else begin
        rem <= trial;
        dq  <= {dq[`BXA_DVD_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      avg_count_o <= 16'h0000;
    end else if (acq_start_i) begin
      avg_count_o <= 16'h0000;
    end else if (complete) begin
      avg_count_o <= avg_count_o + 16'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trig_o       <= 1'b0;
      trig_phase_o <= 8'h00;
      trig_group_o <= 16'h0000;
      armed        <= 1'b0;
      prev_s       <= 16'h0000;
      prev_ok      <= 1'b0;
    end else if (acq_start_i) begin
      trig_o  <= 1'b0;
      armed   <= 1'b1;
      prev_ok <= 1'b0;
    end else begin
      trig_o <= 1'b0;
      if (accept) begin
        prev_s  <= sample_i;
        prev_ok <= 1'b1;
        if (trig_en_i && armed && prev_ok && rising_cross(prev_s, sample_i, trig_level_i)) begin
          trig_o       <= 1'b1;
          trig_phase_o <= cnt[7:0];
          trig_group_o <= avg_count_o;
          armed        <= 1'b0;
        end
      end
    end
  end

  bxavg_fifo #(
    .WIDTH (`BXA_OUT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  ((st == bxavg_pkg::BXAVG_PUSH) && !acq_start_i),
    .in_data_i   (result),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (fifo_pop || !fifo_out_valid)
  );

  // registered output stage so the port comes from a flop
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      avg_valid_o <= 1'b0;
      avg_data_o  <= 24'h000000;
    end else if (!avg_valid_o || avg_ready_i) begin
      avg_valid_o <= fifo_out_valid;
      if (fifo_out_valid) begin
        avg_data_o <= fifo_out_data;
      end
    end
  end

  factor_range_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    acq_active_o |-> (fac >= `BXA_FACT_MIN) && (fac <= `BXA_FACT_MAX))
    else $error("factor outside 2 to 256");

  group_launch_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    complete |=> (st == bxavg_pkg::BXAVG_DIV) && (cnt == 9'h000) && (acc == 24'h000000))
    else $error("group end did not clear and launch");

  acc_sum_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (accept && !complete) |=> (acc == $past(acc) + {8'h00, $past(uval)}) && (cnt == $past(cnt) + 9'h001))
    else $error("accumulator missed a sample");

  quotient_exact_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (st == bxavg_pkg::BXAVG_PUSH) |->
      (({8'h00, dq[23:0]} * {23'h000000, fac}) + {22'h000000, rem}) == {dvd_hold, 8'h00} && (rem < {1'b0, fac}))
    else $error("quotient does not match sum over factor");

  div_steps_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (st == bxavg_pkg::BXAVG_DIV && step == `BXA_DIV_LAST && !acq_start_i) |=> (st == bxavg_pkg::BXAVG_PUSH))
    else $error("divider did not finish after 32 steps");

  frac_width_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (st == bxavg_pkg::BXAVG_PUSH && fac == 9'h002) |-> (dq[6:0] == 7'h00))
    else $error("factor two result has more than one fraction bit");

  no_overrun_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    complete |-> (st == bxavg_pkg::BXAVG_IDLE))
    else $error("group completed while divider busy");

  out_rate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!acq_start_i && !complete) |=> $stable(avg_count_o))
    else $error("result count moved without a full group");

  trig_fire_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (accept && trig_en_i && armed && prev_ok && rising_cross(prev_s, sample_i, trig_level_i))
      |=> trig_o && (trig_phase_o == $past(cnt[7:0])) ##1 !trig_o)
    else $error("trigger crossing missed or mispositioned");

  start_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    acq_start_i |=> acq_active_o && (cnt == 9'h000) && (avg_count_o == 16'h0000) && (st == bxavg_pkg::BXAVG_IDLE))
    else $error("start did not begin a clean acquisition");

  out_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (avg_valid_o && !avg_ready_i) |=> avg_valid_o && $stable(avg_data_o))
    else $error("result dropped under back-pressure");

endmodule // bxavg_top

`default_nettype wire
